// ==== include/bwi_cfg.svh ====
// bwi_cfg.svh: register offsets, field positions, reset values and timing figures
// assumes: included by bare name from the boot/wake interrupt output block
`ifndef BWI_CFG_SVH
`define BWI_CFG_SVH

// register byte addresses on the avalon slave
`define BWI_OFS_ENABLES   5'h00
`define BWI_OFS_PIN_SEL   5'h04
`define BWI_OFS_CONFIG    5'h08
`define BWI_OFS_STATUS    5'h0C
`define BWI_OFS_MASK      5'h10
`define BWI_OFS_STATE     5'h14

// irq_output_enables fields
`define BWI_EN_WAKE_OUT   0
`define BWI_EN_BOOT_IRQ_DISABLE   1
// pin select fields
`define BWI_SEL_WAKE_B    0
`define BWI_SEL_BOOT_B    1
// sensor_config_four fields
`define BWI_CFG_POL       0
`define BWI_CFG_PINB_FUNC 1
// status and mask fields
`define BWI_ST_BOOT_PULSE 0
`define BWI_ST_WAKE_ENTER 1
`define BWI_ST_WAKE_LEAVE 2

`define BWI_RST_BYTE      8'h00
`define BWI_SYS_WAKE      2'h1

// timing figures
`define BWI_CLK_KHZ        40000
`define BWI_PULSE_SHORT_US 10
`define BWI_PULSE_LONG_MS  1

`endif

// ==== include/bwi_pkg.sv ====
// bwi_pkg: types of the boot/wake interrupt output block
// assumes: compiled before the rtl files
package bwi_pkg;
	typedef enum logic [2:0] {
		BWI_BOOT_WAIT  = 3'b001,
		BWI_BOOT_PULSE = 3'b010,
		BWI_BOOT_DONE  = 3'b100
	} bwi_boot_e;

	typedef logic [7:0] bwi_byte_t;
endpackage

// ==== rtl/bwi_irq_out.sv ====
// bwi_irq_out: boot-complete pulse and wake-state level on the two interrupt pins
// assumes: boot_done, sys_mode, soft_reset, hibernate_entry come from logic on clock;
// boot_strap_select is a board pin; avalon master holds requests until waitrequest low
`timescale 1ns/1ps
`include "bwi_cfg.svh"
module bwi_irq_out #(
	parameter int unsigned CLK_KHZ        = `BWI_CLK_KHZ,
	parameter int unsigned PULSE_SHORT_US = `BWI_PULSE_SHORT_US,
	parameter int unsigned PULSE_LONG_MS  = `BWI_PULSE_LONG_MS
) (
	input  wire logic          clock,
	input  wire logic          resetn,
	input  wire logic          clk_en,
	input  wire logic [4:0]    avs_address,
	input  wire logic          avs_read,
	input  wire logic          avs_write,
	input  wire logic [31:0]   avs_writedata,
	input  wire logic [3:0]    avs_byteenable,
	output logic [31:0]        avs_readdata,
	output logic               avs_waitrequest,
	input  wire logic          boot_done,
	input  wire logic [1:0]    sys_mode,
	input  wire logic          soft_reset,
	input  wire logic          hibernate_entry,
	input  wire logic          boot_strap_select,
	output logic               irq_pin_a_o,
	output logic               irq_pin_a_oe,
	output logic               irq_pin_b_o,
	output logic               irq_pin_b_oe,
	output logic               irq
);
	import bwi_pkg::*;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	localparam int unsigned SHORT_RAW = (PULSE_SHORT_US * CLK_KHZ) / 1000;
	localparam int unsigned SHORT_CYC = (SHORT_RAW < 1) ? 1 : SHORT_RAW;
	localparam int unsigned LONG_CYC  = (PULSE_LONG_MS * CLK_KHZ < 1) ? 1 : PULSE_LONG_MS * CLK_KHZ;

	bwi_byte_t  enables_q;
	bwi_byte_t  pin_sel_q;
	bwi_byte_t  config_q;
	bwi_byte_t  status_q;
	bwi_byte_t  mask_q;
	bwi_boot_e  boot_state_q;
	logic       strap_meta_q;
	logic       strap_q;
	logic       in_wake_q;
	logic       ack_q;
	logic       pulse_busy;
	logic       boot_fire;
	logic       wr_en;
	logic       boot_on_b;
	logic       wake_on_b;
	logic       boot_act;
	logic       wake_act_a;
	logic       wake_act_b;
	logic       act_a;
	logic       act_b;
	logic       in_wake;
	bwi_byte_t  set_ev;

	function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
		hit = (addr == ofs);
	endfunction

	// strap pin synchroniser
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			strap_meta_q <= 1'b0;
			strap_q      <= 1'b0;
		end else if (clk_en) begin
			strap_meta_q <= boot_strap_select;
			strap_q      <= strap_meta_q;
		end
	end

	// avalon slave: one wait cycle, then the access completes
	assign wr_en = avs_write && !avs_waitrequest && avs_byteenable[0];

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ack_q           <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else if (clk_en) begin
			ack_q           <= (avs_read || avs_write) && !ack_q;
			avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
			if (avs_read && !ack_q) begin
				unique case (1'b1)
					hit(avs_address, `BWI_OFS_ENABLES): avs_readdata <= {24'h000000, enables_q};
					hit(avs_address, `BWI_OFS_PIN_SEL): avs_readdata <= {24'h000000, pin_sel_q};
					hit(avs_address, `BWI_OFS_CONFIG):  avs_readdata <= {24'h000000, config_q};
					hit(avs_address, `BWI_OFS_STATUS):  avs_readdata <= {24'h000000, status_q};
					hit(avs_address, `BWI_OFS_MASK):    avs_readdata <= {24'h000000, mask_q};
					hit(avs_address, `BWI_OFS_STATE):   avs_readdata <= {24'h000000, boot_state_q,
						pulse_busy, strap_q, in_wake_q, irq_pin_b_o, irq_pin_a_o};
					default:                            avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end

	// enables: boot disable kept over soft reset, cleared on hibernate
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			enables_q <= `BWI_RST_BYTE;
		end else if (clk_en) begin
			if (hibernate_entry) begin
				enables_q <= `BWI_RST_BYTE;
			end else if (soft_reset) begin
				enables_q <= enables_q & (8'h01 << `BWI_EN_BOOT_IRQ_DISABLE);
			end else if (wr_en && hit(avs_address, `BWI_OFS_ENABLES)) begin
				enables_q <= avs_writedata[7:0];
			end
		end
	end

	// pin select: boot route also kept over soft reset
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pin_sel_q <= `BWI_RST_BYTE;
		end else if (clk_en) begin
			if (hibernate_entry) begin
				pin_sel_q <= `BWI_RST_BYTE;
			end else if (soft_reset) begin
				pin_sel_q <= pin_sel_q & (8'h01 << `BWI_SEL_BOOT_B);
			end else if (wr_en && hit(avs_address, `BWI_OFS_PIN_SEL)) begin
				pin_sel_q <= avs_writedata[7:0];
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			config_q <= `BWI_RST_BYTE;
			mask_q   <= `BWI_RST_BYTE;
		end else if (clk_en) begin
			if (soft_reset || hibernate_entry) begin
				config_q <= `BWI_RST_BYTE;
				mask_q   <= `BWI_RST_BYTE;
			end else if (wr_en) begin
				if (hit(avs_address, `BWI_OFS_CONFIG)) begin
					config_q <= avs_writedata[7:0];
				end
				if (hit(avs_address, `BWI_OFS_MASK)) begin
					mask_q <= avs_writedata[7:0];
				end
			end
		end
	end

	// boot pulse sequencer: armed at power-up and by soft reset
	assign boot_fire = (boot_state_q == BWI_BOOT_WAIT) && boot_done
		&& (strap_q || !enables_q[`BWI_EN_BOOT_IRQ_DISABLE]);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			boot_state_q <= BWI_BOOT_WAIT;
		end else if (clk_en) begin
			if (soft_reset) begin
				boot_state_q <= BWI_BOOT_WAIT;
			end else begin
				unique case (boot_state_q)
					BWI_BOOT_WAIT: begin
						if (boot_fire) begin
							boot_state_q <= BWI_BOOT_PULSE;
						end else if (boot_done) begin
							boot_state_q <= BWI_BOOT_DONE;
						end
					end
					BWI_BOOT_PULSE: begin
						if (!pulse_busy) begin
							boot_state_q <= BWI_BOOT_DONE;
						end
					end
					BWI_BOOT_DONE: boot_state_q <= BWI_BOOT_DONE;
					default:       boot_state_q <= BWI_BOOT_WAIT;
				endcase
			end
		end
	end

	bwi_pulse_timer #(
		.SHORT_CYC (SHORT_CYC),
		.LONG_CYC  (LONG_CYC),
		.CW        (32)
	) u_timer (
		.clock     (clock),
		.resetn    (resetn),
		.clk_en    (clk_en),
		.start     (boot_fire),
		.use_long  (strap_q),
		.busy_q    (pulse_busy)
	);

	// pin routing; a pin b select is dropped to pin a while b is a trigger input, but the strap keeps the boot pulse on pin b
	assign boot_on_b  = strap_q || (pin_sel_q[`BWI_SEL_BOOT_B] && !config_q[`BWI_CFG_PINB_FUNC]);
	assign wake_on_b  = pin_sel_q[`BWI_SEL_WAKE_B] && !config_q[`BWI_CFG_PINB_FUNC];
	assign in_wake    = (sys_mode == `BWI_SYS_WAKE);
	assign boot_act   = (boot_state_q == BWI_BOOT_PULSE) && pulse_busy;
	assign wake_act_a = enables_q[`BWI_EN_WAKE_OUT] && in_wake && !wake_on_b;
	assign wake_act_b = enables_q[`BWI_EN_WAKE_OUT] && in_wake && wake_on_b && !strap_q;
	assign act_a      = (boot_act && !boot_on_b) || wake_act_a;
	assign act_b      = (boot_act && boot_on_b) || wake_act_b;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			irq_pin_a_o  <= 1'b0;
			irq_pin_a_oe <= 1'b0;
			irq_pin_b_o  <= 1'b0;
			irq_pin_b_oe <= 1'b0;
		end else if (clk_en) begin
			// level follows polarity and inactive level is the opposite, except strapped pin b: driven low while active, released otherwise
			irq_pin_a_o  <= act_a ~^ config_q[`BWI_CFG_POL];
			irq_pin_a_oe <= 1'b1;
			if (strap_q) begin
				irq_pin_b_o  <= 1'b0;
				irq_pin_b_oe <= act_b;
			end else begin
				irq_pin_b_o  <= act_b ~^ config_q[`BWI_CFG_POL];
				irq_pin_b_oe <= !config_q[`BWI_CFG_PINB_FUNC];
			end
		end
	end

	// sticky events, write one to clear, a new event wins over the clear
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			in_wake_q <= 1'b0;
		end else if (clk_en) begin
			in_wake_q <= in_wake;
		end
	end

	always_comb begin
		set_ev = 8'h00;
		set_ev[`BWI_ST_BOOT_PULSE] = boot_fire;
		set_ev[`BWI_ST_WAKE_ENTER] = in_wake && !in_wake_q;
		set_ev[`BWI_ST_WAKE_LEAVE] = !in_wake && in_wake_q;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			status_q <= `BWI_RST_BYTE;
			irq      <= 1'b0;
		end else if (clk_en) begin
			if (wr_en && hit(avs_address, `BWI_OFS_STATUS)) begin
				status_q <= (status_q & ~avs_writedata[7:0]) | set_ev;
			end else begin
				status_q <= status_q | set_ev;
			end
			irq <= |(status_q & mask_q);
		end
	end

	// checks
	// counts busy cycles of the current boot pulse
	logic [31:0] pulse_len_q;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pulse_len_q <= 32'h00000000;
		end else if (clk_en) begin
			pulse_len_q <= boot_fire ? 32'h00000000 : (pulse_busy ? pulse_len_q + 32'h00000001 : pulse_len_q);
		end
	end

	a_boot_fires: assert property (clk_en && !soft_reset && boot_state_q == BWI_BOOT_WAIT && boot_done && !strap_q
		&& !enables_q[`BWI_EN_BOOT_IRQ_DISABLE] |=> boot_state_q == BWI_BOOT_PULSE && pulse_busy)
		else $error("boot pulse not started");
	a_boot_disabled: assert property (clk_en && !soft_reset && boot_state_q == BWI_BOOT_WAIT && boot_done && !strap_q
		&& enables_q[`BWI_EN_BOOT_IRQ_DISABLE] |=> boot_state_q == BWI_BOOT_DONE && !pulse_busy)
		else $error("disabled boot pulse fired");
	a_pulse_length: assert property ($fell(pulse_busy) |->
		pulse_len_q == (strap_q ? LONG_CYC : SHORT_CYC))
		else $error("boot pulse length wrong");
	a_strap_pin_b: assert property (clk_en && strap_q && boot_act |=> irq_pin_b_oe && !irq_pin_b_o)
		else $error("strap pulse not low on pin b");
	a_disable_soft_keep: assert property (clk_en && soft_reset && !hibernate_entry
		|=> enables_q[`BWI_EN_BOOT_IRQ_DISABLE] == $past(enables_q[`BWI_EN_BOOT_IRQ_DISABLE]))
		else $error("boot disable lost on soft reset");
	a_disable_hib_clear: assert property (clk_en && hibernate_entry |=> !enables_q[`BWI_EN_BOOT_IRQ_DISABLE])
		else $error("boot disable kept over hibernate");
	a_wake_off_quiet: assert property (clk_en && !enables_q[`BWI_EN_WAKE_OUT] && !boot_act
		|=> irq_pin_a_o == !$past(config_q[`BWI_CFG_POL]))
		else $error("wake shown while disabled");
	a_wake_level: assert property (clk_en && enables_q[`BWI_EN_WAKE_OUT] && in_wake && !wake_on_b
		|=> irq_pin_a_o == $past(config_q[`BWI_CFG_POL]))
		else $error("wake level wrong");
	a_wake_leave: assert property (clk_en && enables_q[`BWI_EN_WAKE_OUT] && !in_wake && !wake_on_b
		&& !(boot_act && !boot_on_b) |=> irq_pin_a_o == !$past(config_q[`BWI_CFG_POL]))
		else $error("wake exit level wrong");
	a_external_trigger_mode_free: assert property (clk_en && config_q[`BWI_CFG_PINB_FUNC] && !strap_q |=> !irq_pin_b_oe)
		else $error("pin b driven in trigger mode");
	a_one_pulse: assert property (clk_en && boot_state_q == BWI_BOOT_DONE && !soft_reset
		|=> boot_state_q == BWI_BOOT_DONE ##1 boot_state_q != BWI_BOOT_PULSE)
		else $error("boot pulse retriggered");
	a_irq_follows: assert property (clk_en |=> irq == |($past(status_q) & $past(mask_q)))
		else $error("interrupt output wrong");

	// routing, strap, re-arm and sticky event checks
	a_boot_on_a: assert property (clk_en && boot_act && !boot_on_b
		|=> irq_pin_a_o == $past(config_q[`BWI_CFG_POL]))
		else $error("boot pulse level wrong on pin a");
	a_boot_on_b: assert property (clk_en && boot_act && boot_on_b && !strap_q
		|=> irq_pin_b_o == $past(config_q[`BWI_CFG_POL]))
		else $error("boot pulse level wrong on pin b");
	a_wake_pin_b: assert property (clk_en && enables_q[`BWI_EN_WAKE_OUT] && in_wake && wake_on_b && !strap_q
		|=> irq_pin_b_o == $past(config_q[`BWI_CFG_POL]))
		else $error("wake level wrong on pin b");
	a_trig_route_a: assert property (clk_en && config_q[`BWI_CFG_PINB_FUNC] && !strap_q && boot_act
		|=> irq_pin_a_o == $past(config_q[`BWI_CFG_POL]))
		else $error("boot pulse not moved to pin a");
	a_strap_forced: assert property (clk_en && !soft_reset && strap_q && boot_state_q == BWI_BOOT_WAIT
		&& boot_done |=> boot_state_q == BWI_BOOT_PULSE && pulse_busy)
		else $error("strap boot pulse not started");
	a_strap_release: assert property (clk_en && strap_q && !boot_act |=> !irq_pin_b_oe)
		else $error("pin b driven outside strap pulse");
	a_soft_rearm: assert property (clk_en && soft_reset |=> boot_state_q == BWI_BOOT_WAIT)
		else $error("boot sequencer not re-armed");
	a_event_sticky: assert property (clk_en && (set_ev != 8'h00)
		|=> (status_q & $past(set_ev)) == $past(set_ev))
		else $error("event lost against clear");

	c_boot_pulse: cover property (boot_fire && !strap_q);
	c_strap_pulse: cover property (boot_fire && strap_q);
	c_wake_cycle: cover property (set_ev[`BWI_ST_WAKE_ENTER] ##[1:50] set_ev[`BWI_ST_WAKE_LEAVE]);
	c_irq_raised: cover property ($rose(irq));
	c_soft_rearm: cover property (soft_reset ##[1:200] boot_fire);
endmodule // bwi_irq_out

// ==== rtl/bwi_pulse_timer.sv ====
// bwi_pulse_timer: counts one pulse of either of two lengths
// assumes: start is a one-cycle pulse on the same clock; lengths at least one cycle
`timescale 1ns/1ps
module bwi_pulse_timer #(
	parameter int unsigned SHORT_CYC = 400,
	parameter int unsigned LONG_CYC  = 40000,
	parameter int unsigned CW        = 32
) (
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic clk_en,
	input  wire logic start,
	input  wire logic use_long,
	output logic      busy_q
);
	logic [CW-1:0] left_q;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			left_q <= '0;
			busy_q <= 1'b0;
		end else if (clk_en) begin
			if (start) begin
				left_q <= use_long ? CW'(LONG_CYC - 1) : CW'(SHORT_CYC - 1);
				busy_q <= 1'b1;
			end else if (busy_q) begin
				if (left_q == '0) begin
					busy_q <= 1'b0;
				end else begin
					left_q <= left_q - CW'(1);
				end
			end
		end
	end
endmodule // bwi_pulse_timer

// ==== tb/bwi_host_model.sv ====
// bwi_host_model: host controller and load switch seen on the two interrupt pins
// assumes: both pins carry pull-ups; pin levels counted on clock
`timescale 1ns/1ps
module bwi_host_model (
	input  wire logic clock,
	input  wire logic pin_a_o,
	input  wire logic pin_a_oe,
	input  wire logic pin_b_o,
	input  wire logic pin_b_oe,
	output logic      pin_a,
	output logic      pin_b,
	output int        edges_a,
	output int        edges_b
);
	logic prev_a;
	logic prev_b;

	// an undriven pin floats to its pull-up level
	assign pin_a = pin_a_oe ? pin_a_o : 1'b1;
	assign pin_b = pin_b_oe ? pin_b_o : 1'b1;

	// released pins idle high, so the edge history starts there
	initial begin
		edges_a = 0;
		edges_b = 0;
		prev_a  = 1'b1;
		prev_b  = 1'b1;
	end

	// level changes are counted on both resolved pins, each against its level one cycle earlier
	always @(posedge clock) begin
		prev_a <= pin_a;
		prev_b <= pin_b;
		if (pin_a !== prev_a)
			edges_a <= edges_a + 1;
		if (pin_b !== prev_b)
			edges_b <= edges_b + 1;
	end
endmodule // bwi_host_model

// ==== tb/tb_bwi_irq_out.sv ====
// tb_bwi_irq_out: self-checking bench for the boot/wake interrupt output block
// assumes: short pulse timing parameters; pins resolved by bwi_host_model
`timescale 1ns/1ps
`include "bwi_cfg.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_bwi_irq_out;
	import bwi_pkg::*;
	localparam int CK    = 100;
	localparam int SUS   = 50;
	localparam int LMS   = 1;
	localparam int SHORT = CK * SUS / 1000;
	localparam int LONG  = CK * LMS;

	logic        clock = 1'b0;
	logic        resetn = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        boot_done = 1'b0;
	logic [1:0]  sys_mode = 2'h0;
	logic        soft_reset = 1'b0;
	logic        hibernate_entry = 1'b0;
	logic        strap = 1'b0;
	logic        pa_o, pa_oe, pb_o, pb_oe, irq, pin_a, pin_b;
	int          edges_a, edges_b, n_errors = 0, num_checks = 0;

	always #12.5 clock = ~clock;

	bwi_irq_out #(.CLK_KHZ(CK), .PULSE_SHORT_US(SUS), .PULSE_LONG_MS(LMS)) u_dut (
		.clock(clock), .resetn(resetn), .clk_en(1'b1), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.boot_done(boot_done), .sys_mode(sys_mode), .soft_reset(soft_reset),
		.hibernate_entry(hibernate_entry), .boot_strap_select(strap), .irq_pin_a_o(pa_o),
		.irq_pin_a_oe(pa_oe), .irq_pin_b_o(pb_o), .irq_pin_b_oe(pb_oe), .irq(irq));

	bwi_host_model u_host (.clock(clock), .pin_a_o(pa_o), .pin_a_oe(pa_oe), .pin_b_o(pb_o),
		.pin_b_oe(pb_oe), .pin_a(pin_a), .pin_b(pin_b), .edges_a(edges_a), .edges_b(edges_b));

	task summarize;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task step(input int n);
		repeat (n) @(posedge clock);
	endtask

	// one avalon access, held until waitrequest is sampled low
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		int i;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 50);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (i >= 50) begin
			n_errors++;
			summarize();
		end
	endtask

	task wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task rd(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		`CHK(q, e)
	endtask

	// one-cycle pulse: 0 boot done, 1 soft reset, 2 hibernate entry
	task pulse(input int k);
		@(posedge clock);
		boot_done <= (k == 0);
		soft_reset <= (k == 1);
		hibernate_entry <= (k == 2);
		@(posedge clock);
		boot_done <= 1'b0;
		soft_reset <= 1'b0;
		hibernate_entry <= 1'b0;
	endtask

	// cycles a resolved pin spends at level act, waiting a bounded time for it
	task width(input bit b, input logic act, output int w);
		int i;
		w = 0;
		for (i = 0; i < 20 && (b ? pin_b : pin_a) !== act; i++)
			@(negedge clock);
		while ((b ? pin_b : pin_a) === act && w < 300) begin
			w++;
			@(negedge clock);
		end
		@(posedge clock);
		if (i >= 20 || w >= 300) begin
			n_errors++;
			summarize();
		end
	endtask

	initial begin
		int w;
		int ed;
		step(6);
		resetn <= 1'b1;
		step(4);
		`CHK(pin_a, 1'b1)
		rd(`BWI_OFS_ENABLES, 32'h0);
		rd(`BWI_OFS_PIN_SEL, 32'h0);
		rd(5'h18, 32'h0);
		pulse(0);
		width(0, 1'b0, w);
		`CHK(w, SHORT)
		rd(`BWI_OFS_STATUS, 32'h1);
		`CHK(irq, 1'b0)
		wr(`BWI_OFS_MASK, 32'h1);
		step(2);
		`CHK(irq, 1'b1)
		wr(`BWI_OFS_STATUS, 32'h1);
		step(2);
		`CHK(irq, 1'b0)
		ed = edges_a + edges_b;
		pulse(0);
		step(30);
		`CHK(edges_a + edges_b - ed, 0)
		$display("test boot short pulse done");
		wr(`BWI_OFS_ENABLES, 32'h3);
		pulse(1);
		rd(`BWI_OFS_ENABLES, 32'h2);
		ed = edges_a + edges_b;
		pulse(0);
		step(30);
		`CHK(edges_a + edges_b - ed, 0)
		pulse(2);
		rd(`BWI_OFS_ENABLES, 32'h0);
		pulse(1);
		wr(`BWI_OFS_CONFIG, 32'h1);
		wr(`BWI_OFS_PIN_SEL, 32'h2);
		pulse(0);
		width(1, 1'b1, w);
		`CHK(w, SHORT)
		$display("test boot disable and route done");
		sys_mode <= `BWI_SYS_WAKE;
		step(3);
		`CHK(pin_a, 1'b0)
		wr(`BWI_OFS_ENABLES, 32'h1);
		step(2);
		`CHK(pin_a, 1'b1)
		sys_mode <= 2'h2;
		step(3);
		`CHK(pin_a, 1'b0)
		sys_mode <= `BWI_SYS_WAKE;
		wr(`BWI_OFS_PIN_SEL, 32'h1);
		step(2);
		`CHK(pin_b, 1'b1)
		`CHK(pin_a, 1'b0)
		wr(`BWI_OFS_CONFIG, 32'h3);
		step(2);
		`CHK(pin_a, 1'b1)
		rd(`BWI_OFS_STATUS, 32'h7);
		sys_mode <= 2'h0;
		wr(`BWI_OFS_ENABLES, 32'h0);
		$display("test wake output done");
		strap <= 1'b1;
		step(4);
		pulse(1);
		wr(`BWI_OFS_ENABLES, 32'h2);
		wr(`BWI_OFS_PIN_SEL, 32'h0);
		pulse(0);
		width(1, 1'b0, w);
		`CHK(w, LONG)
		`CHK(pb_oe, 1'b0)
		$display("test strap long pulse done");
		summarize();
	end
endmodule // tb_bwi_irq_out
